// file: hdl/plci_top.sv
// plci_top: link-change status and mask registers with interrupt output
// assumes single-cycle register read/write strobes from the switch access port
// How it works
// R1 - link change on port n sets status bit n-1
// R2 - status sticks until one written to it
// R3 - status reads one when pending, resets zero
// R4 - mask bits 4:0, one masks the port
// R5 - mask read/write, resets zero, bits 7:5 zero
// R6 - irq high while any unmasked status bit set
`default_nettype none
module plci_top
    import plci_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic [NUM_PORTS-1:0] link_up,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    output logic      [7:0]           reg_rdata,
    output logic                      irq
);
    plci_state_s            st;
    plci_state_s            next_st;
    plci_req_s              req;
    logic [NUM_PORTS-1:0]   link_change;

    function automatic logic [7:0] pad_reg(input logic [4:0] v);
        return {RESERVED_READ, v};
    endfunction : pad_reg

    assign req = '{wr_en: reg_wr, rd_en: reg_rd, addr: reg_addr, wdata: reg_wdata};

    plci_link_edge u_edge (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .link_up     (link_up),
        .link_change (link_change)
    );

    always_comb begin
        next_st = st;
        // clear first, then set so a same-cycle event wins
        if (req.wr_en && req.addr == ADDR_IRQ_STATUS) begin
            next_st.status = st.status & ~req.wdata[4:0]; // [R2]
        end
        next_st.status = next_st.status | link_change; // [R1]
        if (req.wr_en && req.addr == ADDR_IRQ_MASK) begin
            next_st.mask = req.wdata[4:0]; // [R4] [R5]
        end
        if (req.rd_en) begin
            case (req.addr)
                ADDR_IRQ_STATUS: next_st.rdata = pad_reg(st.status); // [R3]
                ADDR_IRQ_MASK:   next_st.rdata = pad_reg(st.mask); // [R5]
                default:         next_st.rdata = 8'h00;
            endcase
        end
        next_st.irq = |(next_st.status & ~next_st.mask); // [R6]
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st <= '{status: STATUS_RESET, mask: MASK_RESET, rdata: 8'h00, irq: 1'b0}; // [R3]
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign irq       = st.irq;

    chk_irq_matches_state: assert property (@(posedge sys_clk) disable iff (rst) // [R6]
        irq == |(st.status & ~st.mask))
        else $error("irq disagrees with status and mask");

    chk_change_sets_bit: assert property (@(posedge sys_clk) disable iff (rst) // [R1]
        |link_change |=> ((st.status & $past(link_change)) == $past(link_change)))
        else $error("link change did not set status");

    chk_status_sticks: assert property (@(posedge sys_clk) disable iff (rst) // [R2]
        !(reg_wr && reg_addr == ADDR_IRQ_STATUS) |=> (st.status & $past(st.status)) == $past(st.status))
        else $error("status bit dropped without clear");

    chk_w1c_clears: assert property (@(posedge sys_clk) disable iff (rst) // [R2]
        (reg_wr && reg_addr == ADDR_IRQ_STATUS && reg_wdata[0] && !link_change[0])
        |=> !st.status[0])
        else $error("write one did not clear status");

    chk_reset_zero: assert property (@(posedge sys_clk) // [R3]
        rst |=> (st.status == 5'h00 && st.mask == 5'h00 && !irq && reg_rdata == 8'h00))
        else $error("state not zero after reset");

    chk_mask_write: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
        (reg_wr && reg_addr == ADDR_IRQ_MASK) |=> st.mask == $past(reg_wdata[4:0]))
        else $error("mask write not stored");

    chk_mask_readback: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
        (reg_rd && reg_addr == ADDR_IRQ_MASK) |=> reg_rdata == {3'h0, $past(st.mask)})
        else $error("mask readback wrong");

    chk_status_readback: assert property (@(posedge sys_clk) disable iff (rst) // [R3]
        (reg_rd && reg_addr == ADDR_IRQ_STATUS) |=> reg_rdata == {3'h0, $past(st.status)})
        else $error("status readback wrong");

    chk_zero_write_keeps: assert property (@(posedge sys_clk) disable iff (rst) // [R2]
        (reg_wr && reg_addr == ADDR_IRQ_STATUS && reg_wdata[4:0] == 5'h00)
        |=> (st.status & $past(st.status)) == $past(st.status))
        else $error("zero write changed status");

    chk_rdata_holds: assert property (@(posedge sys_clk) disable iff (rst) // [R3]
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");

    chk_unmapped_zero: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
        (reg_rd && reg_addr != ADDR_IRQ_STATUS && reg_addr != ADDR_IRQ_MASK)
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    chk_no_spurious_set: assert property (@(posedge sys_clk) disable iff (rst) // [R3]
        1'b1 |=> (st.status & ~$past(st.status) & ~$past(link_change)) == 5'h00)
        else $error("status set without link change");

    chk_masked_quiet: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
        (st.mask == 5'h1f) |-> !irq)
        else $error("irq raised with all ports masked");

    cov_irq_rise: cover property (@(posedge sys_clk) disable iff (rst) $rose(irq));
    cov_clear: cover property (@(posedge sys_clk) disable iff (rst)
        irq ##1 (reg_wr && reg_addr == ADDR_IRQ_STATUS) ##1 !irq);
    cov_set_clear_race: cover property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == ADDR_IRQ_STATUS && |(reg_wdata[4:0] & link_change));
    cov_masked_change: cover property (@(posedge sys_clk) disable iff (rst)
        |(link_change & st.mask));
endmodule : plci_top
`default_nettype wire

// file: hdl/plci_pkg.sv
// plci_pkg: constants and carrier types for the port link-change interrupt block
// assumes an 8-bit internal register access port shared by the switch
`default_nettype none
package plci_pkg;
    localparam int          NUM_PORTS       = 5;
    localparam logic [7:0]  ADDR_IRQ_STATUS = 8'h7c;
    localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h7d;
    localparam logic [4:0]  STATUS_RESET    = 5'h00;
    localparam logic [4:0]  MASK_RESET      = 5'h00;
    localparam logic [2:0]  RESERVED_READ   = 3'h0;
    // edges after reset until the whole sync chain holds real samples
    localparam logic [1:0]  PRIME_CYCLES    = 2'h3;

    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } plci_req_s;

    typedef struct packed {
        logic [4:0] link_sync1;
        logic [4:0] link_sync2;
        logic [4:0] link_prev;
        logic [1:0] prime_cnt;
    } plci_sync_s;

    typedef struct packed {
        logic [4:0] status;
        logic [4:0] mask;
        logic [7:0] rdata;
        logic       irq;
    } plci_state_s;
endpackage : plci_pkg
`default_nettype wire

// file: hdl/plci_link_edge.sv
// plci_link_edge: synchronises per-port link levels and pulses on change
// assumes link_up comes from PHY logic outside this clock domain
`default_nettype none
module plci_link_edge
    import plci_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic [NUM_PORTS-1:0] link_up,
    output logic      [NUM_PORTS-1:0] link_change
);
    plci_sync_s s;
    plci_sync_s next_s;

    always_comb begin
        next_s            = s;
        next_s.link_sync1 = link_up;
        next_s.link_sync2 = s.link_sync1;
        next_s.link_prev  = s.link_sync2;
        if (s.prime_cnt != PRIME_CYCLES) begin
            next_s.prime_cnt = s.prime_cnt + 2'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // no change until prev holds a real sample, so a level already up at reset is quiet
    assign link_change = (s.prime_cnt == PRIME_CYCLES) ? (s.link_sync2 ^ s.link_prev) : '0;
endmodule : plci_link_edge
`default_nettype wire

// file: test/tb_port_link_change_interrupts.sv
// tb_port_link_change_interrupts: random and corner tests of plci_top
// assumes read data is registered and holds until the next read
`default_nettype none
module tb_port_link_change_interrupts;
    timeunit 1ns;
    timeprecision 1ps;
    import plci_pkg::*;
    logic       sys_clk   = 1'b0;
    logic       rst       = 1'b1;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic [4:0] link_up   = 5'h00;
    logic [7:0] reg_addr  = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic       irq;
    logic [4:0] st        = 5'h00;
    logic [4:0] mk        = 5'h00;
    logic [4:0] r;
    int         bad_count = 0;
    int         cmp_count = 0;
    integer     seed      = 32'hfdeafeed;

    plci_top u_plci_top (.sys_clk(sys_clk), .rst(rst), .link_up(link_up), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .irq(irq));

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    task chk(input string n, input logic [7:0] e, input logic [7:0] s);
        cmp_count++;
        if (s !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, s);
            bad_count++;
        end
    endtask : chk

    function automatic logic [7:0] exp_reg(input logic [4:0] v);
        return {3'h0, v};
    endfunction : exp_reg

    function automatic logic exp_irq(input logic [4:0] s, input logic [4:0] m);
        return |(s & ~m);
    endfunction : exp_irq

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] e, input string n);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk(n, e, reg_rdata);
    endtask : rd

    task toggle(input logic [4:0] m);
        @(posedge sys_clk);
        link_up <= link_up ^ m;
        repeat (4) @(posedge sys_clk);
        st = st | m;
    endtask : toggle

    // write-one clear lands on the edge where the change sets the bit
    task race(input logic [4:0] m);
        @(posedge sys_clk);
        link_up   <= link_up ^ m;
        repeat (2) @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= ADDR_IRQ_STATUS;
        reg_wdata <= {3'h0, m};
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        st = st | m;
    endtask : race

    task check_all;
        rd(ADDR_IRQ_STATUS, exp_reg(st), "status");
        rd(ADDR_IRQ_MASK, exp_reg(mk), "mask");
        chk("irq", {7'h00, exp_irq(st, mk)}, {7'h00, irq});
    endtask : check_all

    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        print_verdict();
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check_all();
        rd(8'h7e, 8'h00, "unmapped");
        $display("reset test done");
        wr(ADDR_IRQ_MASK, 8'hff);
        mk = 5'h1f;
        toggle(5'h1f);
        check_all();
        wr(ADDR_IRQ_STATUS, 8'h00);
        wr(8'h7e, 8'hff);
        check_all();
        wr(ADDR_IRQ_STATUS, 8'h1f);
        st = 5'h00;
        race(5'h04);
        check_all();
        $display("corner test done");
        // reset again with links up: no change may be seen after release
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        st = 5'h00;
        mk = 5'h00;
        repeat (4) @(posedge sys_clk);
        check_all();
        $display("reset rerun test done");
        for (int i = 0; i < 60; i++) begin
            r = 5'($random(seed));
            case (3'($random(seed)))
                3'd0: toggle(r);
                3'd1: begin
                    wr(ADDR_IRQ_MASK, {3'h7, r});
                    mk = r;
                end
                3'd2: begin
                    wr(ADDR_IRQ_STATUS, {3'h7, r});
                    st = st & ~r;
                end
                3'd3: wr(ADDR_IRQ_STATUS, 8'h00);
                3'd4: race(r);
                default: toggle(r);
            endcase
            check_all();
        end
        $display("random test done");
        print_verdict();
    end
endmodule : tb_port_link_change_interrupts
`default_nettype wire
